/* File: rtl/tbst_defs.vh */
`ifndef TBST_DEFS_VH
`define TBST_DEFS_VH

// Instruction register width and opcodes
`define TBST_IR_W 4
`define TBST_OP_CLAMP 4'h0
`define TBST_OP_EXTEST 4'h1
`define TBST_OP_PULSE 4'h2
`define TBST_OP_TRAIN 4'h3
`define TBST_OP_INTEST 4'h4
`define TBST_OP_SAMPLE 4'h5
`define TBST_OP_HIGHZ 4'h6
`define TBST_OP_INSTR 4'h7
`define TBST_OP_IDCODE 4'h8

// Value loaded at reset and at capture of the instruction register
`define TBST_IR_RESET 4'h8
`define TBST_IR_CAPTURE 4'h1

// Identification register width and default (arbitrary value)
`define TBST_ID_W 32
`define TBST_ID_DEFAULT 32'h0ABC0001

// Boundary cells per digital pin: input, output, enable
`define TBST_CELLS_PER_PIN 3
`define TBST_CELL_IN 0
`define TBST_CELL_OUT 1
`define TBST_CELL_OE 2

`endif

/* File: rtl/tbst_tap.v */
`timescale 1ns/1ps
`include "tbst_defs.vh"

module tbst_tap #(
  parameter NPIN = 8,                    // Digital pins with boundary cells
  parameter IJW = 8,                     // Instrument chain length
  parameter [31:0] IDCODE = `TBST_ID_DEFAULT // Arbitrary identity value
) (
  input wire i_mclk,                     // Block clock, 10 MHz
  input wire i_srst,                     // Synchronous reset, active high
  input wire i_scan_port_select_pin,     // Test-select pin, async
  input wire i_pin_tck,                  // Test clock pin, async
  input wire i_pin_tms,                  // Mode select pin, async
  input wire i_pin_tdi,                  // Test data in pin, async
  output wire o_pin_tdo,                 // Test data out pin level
  output wire o_pin_tdo_oe,              // Test data out pin enable
  input wire i_gpio_tdo_out,             // GPIO drive for the data-out pin
  input wire i_gpio_tdo_oe,              // GPIO enable for the data-out pin
  output wire [2:0] o_gpio_in,           // Shared pin levels for GPIO use
  input wire [NPIN-1:0] i_core_out,      // Core output data per pin
  input wire [NPIN-1:0] i_core_oe,       // Core output enable per pin
  input wire [NPIN-1:0] i_pad_in,        // Pad input levels, async
  output wire [NPIN-1:0] o_pad_out,      // Pad output data
  output wire [NPIN-1:0] o_pad_oe,       // Pad output enable
  output wire [NPIN-1:0] o_core_in,      // Pad input as seen by core
  output reg [IJW-1:0] o_instr_data_q    // Instrument chain update value
);

  ////////////////////////////////////////////////////////////////////////
  // TAP states, binary coded
  localparam [3:0] S_TLR = 4'h0;
  localparam [3:0] S_RTI = 4'h1;
  localparam [3:0] S_SELDR = 4'h2;
  localparam [3:0] S_CAPDR = 4'h3;
  localparam [3:0] S_SHDR = 4'h4;
  localparam [3:0] S_EX1DR = 4'h5;
  localparam [3:0] S_PADR = 4'h6;
  localparam [3:0] S_EX2DR = 4'h7;
  localparam [3:0] S_UPDR = 4'h8;
  localparam [3:0] S_SELIR = 4'h9;
  localparam [3:0] S_CAPIR = 4'hA;
  localparam [3:0] S_SHIR = 4'hB;
  localparam [3:0] S_EX1IR = 4'hC;
  localparam [3:0] S_PAIR = 4'hD;
  localparam [3:0] S_EX2IR = 4'hE;
  localparam [3:0] S_UPIR = 4'hF;

  // Boundary chain length; analog pins are never counted here
  localparam BSW = NPIN * `TBST_CELLS_PER_PIN;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two stages before anything reads the pins
  reg [3:0] sync1_q; // First stage, read only by the second
  reg [3:0] sync2_q; // Second stage
  reg tck_prev_q; // Previous synced test clock, for edge finding
  reg [NPIN-1:0] pad1_q; // First stage of pad inputs
  reg [NPIN-1:0] pad2_q; // Second stage of pad inputs

  always @(posedge i_mclk) begin
    sync1_q <= {i_scan_port_select_pin, i_pin_tck, i_pin_tms, i_pin_tdi};
    sync2_q <= sync1_q;
    pad1_q <= i_pad_in;
    pad2_q <= pad1_q;
  end

  wire sel = sync2_q[3]; // Test-select level
  wire tck = sync2_q[2]; // Test clock level
  wire tms = sync2_q[1]; // Mode select level
  wire tdi = sync2_q[0]; // Data in level

  // Edges of the test clock, each a one-cycle pulse
  wire tck_rise = sel & tck & ~tck_prev_q;
  wire tck_fall = sel & ~tck & tck_prev_q;

  always @(posedge i_mclk) begin
    if (i_srst) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction decode helpers, each used in one place
  function is_bsr;
    input [3:0] op;
    begin
      is_bsr = (op == `TBST_OP_EXTEST) || (op == `TBST_OP_PULSE) ||
               (op == `TBST_OP_TRAIN) || (op == `TBST_OP_INTEST) ||
               (op == `TBST_OP_SAMPLE);
    end
  endfunction

  function is_ext;
    input [3:0] op;
    begin
      // Instructions that put update cells onto the pads
      is_ext = (op <= `TBST_OP_TRAIN);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // TAP state machine, steps on each test-clock rise
  reg [3:0] state_q; // Current TAP state
  reg [3:0] state_d; // Next TAP state

  always @* begin
    case (state_q)
      S_TLR: state_d = tms ? S_TLR : S_RTI;
      S_RTI: state_d = tms ? S_SELDR : S_RTI;
      S_SELDR: state_d = tms ? S_SELIR : S_CAPDR;
      S_CAPDR: state_d = tms ? S_EX1DR : S_SHDR;
      S_SHDR: state_d = tms ? S_EX1DR : S_SHDR;
      S_EX1DR: state_d = tms ? S_UPDR : S_PADR;
      S_PADR: state_d = tms ? S_EX2DR : S_PADR;
      S_EX2DR: state_d = tms ? S_UPDR : S_SHDR;
      S_UPDR: state_d = tms ? S_SELDR : S_RTI;
      S_SELIR: state_d = tms ? S_TLR : S_CAPIR;
      S_CAPIR: state_d = tms ? S_EX1IR : S_SHIR;
      S_SHIR: state_d = tms ? S_EX1IR : S_SHIR;
      S_EX1IR: state_d = tms ? S_UPIR : S_PAIR;
      S_PAIR: state_d = tms ? S_EX2IR : S_PAIR;
      S_EX2IR: state_d = tms ? S_UPIR : S_SHIR;
      S_UPIR: state_d = tms ? S_SELDR : S_RTI;
      default: state_d = S_TLR;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift registers, all captured and shifted on test-clock rise
  reg [3:0] ir_sh_q; // Instruction shift stage
  reg [3:0] ir_q; // Active instruction
  reg byp_q; // Single-stage bypass
  reg [31:0] id_sh_q; // Identification shift stage
  reg [BSW-1:0] bs_sh_q; // Boundary shift stage
  reg [BSW-1:0] bs_up_q; // Boundary update stage
  reg [IJW-1:0] ij_sh_q; // Instrument shift stage
  reg tdo_q; // Data-out level, changes on fall
  reg tdo_oe_q; // Data-out enable, high while shifting
  reg rti_tog_q; // Toggles each rise in idle, for pulse tests

  // Capture image of the pins, three cells per digital pin
  wire [BSW-1:0] bs_cap;
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_cell
      assign bs_cap[g*3+`TBST_CELL_IN] = pad2_q[g];
      assign bs_cap[g*3+`TBST_CELL_OUT] = i_core_out[g];
      assign bs_cap[g*3+`TBST_CELL_OE] = i_core_oe[g];
    end
  endgenerate

  wire sel_bsr = is_bsr(ir_q);
  wire sel_id = (ir_q == `TBST_OP_IDCODE);
  wire sel_ij = (ir_q == `TBST_OP_INSTR);
  // Every other opcode, 1001-1111 included, falls to bypass
  wire sel_byp = ~sel_bsr & ~sel_id & ~sel_ij;

  // Leaving test mode parks the TAP in reset so re-entry starts clean
  always @(posedge i_mclk) begin
    if (i_srst || !sel) begin
      state_q <= S_TLR;
      ir_q <= `TBST_IR_RESET;
      ir_sh_q <= `TBST_IR_RESET;
      byp_q <= 1'b0;
      id_sh_q <= 32'h00000000;
      bs_sh_q <= {BSW{1'b0}};
      ij_sh_q <= {IJW{1'b0}};
      rti_tog_q <= 1'b0;
    end else if (tck_rise) begin
      state_q <= state_d;
      rti_tog_q <= (state_q == S_RTI) ? ~rti_tog_q : 1'b0;
      case (state_q)
        S_TLR: begin
          ir_q <= `TBST_IR_RESET;
        end
        S_CAPIR: begin
          ir_sh_q <= `TBST_IR_CAPTURE;
        end
        S_SHIR: begin
          ir_sh_q <= {tdi, ir_sh_q[3:1]};
        end
        S_CAPDR: begin
          byp_q <= 1'b0;
          id_sh_q <= {IDCODE[31:1], 1'b1};
          if (sel_bsr) begin
            bs_sh_q <= bs_cap;
          end
          if (sel_ij) begin
            ij_sh_q <= o_instr_data_q;
          end
        end
        S_SHDR: begin
          byp_q <= tdi;
          id_sh_q <= {tdi, id_sh_q[31:1]};
          if (sel_bsr) begin
            bs_sh_q <= {tdi, bs_sh_q[BSW-1:1]};
          end
          if (sel_ij) begin
            ij_sh_q <= {tdi, ij_sh_q[IJW-1:1]};
          end
        end
        default: begin
          // Other states hold the shift stages
        end
      endcase
    end else if (tck_fall && state_q == S_UPIR) begin
      // Instruction takes effect mid-cycle of update, per usual TAP
      ir_q <= ir_sh_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Update stages and data-out, all changed on test-clock fall
  always @(posedge i_mclk) begin
    if (i_srst || !sel) begin
      bs_up_q <= {BSW{1'b0}};
      o_instr_data_q <= {IJW{1'b0}};
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      if (state_q == S_UPDR && sel_bsr && ir_q != `TBST_OP_INTEST) begin
        bs_up_q <= bs_sh_q;
      end else if (state_q == S_UPDR && ir_q == `TBST_OP_INTEST) begin
        bs_up_q <= bs_sh_q;
      end
      if (state_q == S_UPDR && sel_ij) begin
        o_instr_data_q <= ij_sh_q;
      end
      tdo_oe_q <= (state_q == S_SHDR) || (state_q == S_SHIR);
      if (state_q == S_SHIR) begin
        tdo_q <= ir_sh_q[0];
      end else if (state_q == S_SHDR) begin
        if (sel_id) begin
          tdo_q <= id_sh_q[0];
        end else if (sel_bsr) begin
          tdo_q <= bs_sh_q[0];
        end else if (sel_ij) begin
          tdo_q <= ij_sh_q[0];
        end else begin
          tdo_q <= byp_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin routing: test logic owns the pads only while selected
  wire ext_mode = sel & is_ext(ir_q) & (ir_q != `TBST_OP_CLAMP);
  wire clamp_mode = sel & (ir_q == `TBST_OP_CLAMP);
  wire hiz_mode = sel & (ir_q == `TBST_OP_HIGHZ);
  wire intest_mode = sel & (ir_q == `TBST_OP_INTEST);
  // Pulse variants invert outputs in idle; train toggles each rise
  wire pulse_inv = sel & (state_q == S_RTI) &
    (((ir_q == `TBST_OP_PULSE)) | ((ir_q == `TBST_OP_TRAIN) & rti_tog_q));

  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pad
      wire up_out = bs_up_q[g*3+`TBST_CELL_OUT];
      wire up_oe = bs_up_q[g*3+`TBST_CELL_OE];
      assign o_pad_out[g] = (ext_mode | clamp_mode) ?
        (up_out ^ pulse_inv) : i_core_out[g];
      assign o_pad_oe[g] = hiz_mode ? 1'b0 :
        (ext_mode | clamp_mode) ? up_oe : i_core_oe[g];
      assign o_core_in[g] = intest_mode ?
        bs_up_q[g*3+`TBST_CELL_IN] : pad2_q[g];
    end
  endgenerate

  // Shared port pins: GPIO use unless the test-select pin is high
  assign o_pin_tdo = sel ? tdo_q : i_gpio_tdo_out;
  assign o_pin_tdo_oe = sel ? tdo_oe_q : i_gpio_tdo_oe;
  assign o_gpio_in = sel ? 3'h0 : {tck, tms, tdi};

endmodule // tbst_tap

/* File: verif/boundary_scan_tap_tb.sv */
`timescale 1ns/1ps
module boundary_scan_tap_tb;
  localparam logic [31:0] ID = 32'h2468ACE1; // Arbitrary identity, lsb one
  logic i_mclk = 1'b0, i_srst = 1'b1, i_scan_port_select_pin = 1'b1;
  logic i_gpio_tdo_out = 1'b0, i_gpio_tdo_oe = 1'b0;
  logic [7:0] i_core_out = 8'h3C, i_core_oe = 8'hF0, i_pad_in = 8'hA5;
  wire i_pin_tck, i_pin_tms, i_pin_tdi, o_pin_tdo, o_pin_tdo_oe;
  wire [2:0] o_gpio_in;
  wire [7:0] o_pad_out, o_pad_oe, o_core_in, o_instr_data_q;
  logic [31:0] got; // Bits read by the last scan
  int errors = 0, cmp_count = 0;
  tbst_tap #(.IDCODE(ID)) tbst_tap_i (.i_mclk, .i_srst,
    .i_scan_port_select_pin, .i_pin_tck, .i_pin_tms, .i_pin_tdi, .o_pin_tdo,
    .o_pin_tdo_oe, .i_gpio_tdo_out, .i_gpio_tdo_oe, .o_gpio_in, .i_core_out,
    .i_core_oe, .i_pad_in, .o_pad_out, .o_pad_oe, .o_core_in,
    .o_instr_data_q);
  tbst_ctl tbst_ctl_i (.i_mclk, .i_pin_tdo(o_pin_tdo), .o_tck(i_pin_tck),
    .o_tms(i_pin_tms), .o_tdi(i_pin_tdi));
  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_ident;
    tbst_ctl_i.scan(32'h0, 32, 1'b0, got);
    check("idcode", got, ID);
    check("id_lsb", got[0], 1'b1);
  endtask
  // Every upper opcode: IR capture pattern, then one cleared bypass stage
  task automatic t_bypass;
    for (int op = 9; op < 16; op++) begin
      tbst_ctl_i.scan(32'(op), 4, 1'b1, got);
      check("ir_capture", got[3:0], 4'h1);
      tbst_ctl_i.scan(32'h3, 2, 1'b0, got);
      check("bypass", got[1:0], 2'h2);
    end
  endtask
  // Sample the pins, preload, then walk opcodes 0 to 6
  task automatic t_boundary;
    logic [23:0] cap, p;
    logic [7:0] ei, eo, ee;
    p = 24'hB6D5A3;
    for (int i = 0; i < 8; i++) begin
      cap[3*i +: 3] = {i_core_oe[i], i_core_out[i], i_pad_in[i]};
      {ee[i], eo[i], ei[i]} = p[3*i +: 3];
    end
    tbst_ctl_i.scan(32'h5, 4, 1'b1, got);
    tbst_ctl_i.scan({8'h0, p}, 24, 1'b0, got);
    check("sample", got[23:0], cap);
    for (int op = 0; op < 7; op++) begin
      tbst_ctl_i.scan(32'(op), 4, 1'b1, got);
      if (op < 4) check("pad_oe", o_pad_oe, ee);
      if (op < 2) check("pad_out", o_pad_out, eo);
      if (op == 2) check("pulse", o_pad_out, eo ^ 8'hFF);
      if (op == 4) check("intest", o_core_in, ei);
      if (op == 6) check("highz", o_pad_oe, 8'h00);
    end
  endtask
  task automatic t_instr;
    tbst_ctl_i.scan(32'h7, 4, 1'b1, got);
    tbst_ctl_i.scan(32'h6B, 8, 1'b0, got);
    check("instr_q", o_instr_data_q, 8'h6B);
    tbst_ctl_i.scan(32'h0, 8, 1'b0, got);
    check("instr_cap", got[7:0], 8'h6B);
  endtask
  // Drop select: pins fall back to GPIO; raise it: port idle, undriven
  task automatic t_gpio;
    @(negedge i_mclk);
    i_scan_port_select_pin = 1'b0;
    i_gpio_tdo_out = 1'b1;
    i_gpio_tdo_oe = 1'b1;
    repeat (6) @(negedge i_mclk);
    check("gpio_tdo", {o_pin_tdo, o_pin_tdo_oe}, 2'h3);
    // GPIO drive stays high, so a pin left on GPIO would show here
    i_scan_port_select_pin = 1'b1;
    repeat (6) @(negedge i_mclk);
    check("sel_oe", {o_pin_tdo, o_pin_tdo_oe}, 2'h0);
    tbst_ctl_i.reset_tap();
  endtask
  initial begin
    repeat (5) @(negedge i_mclk);
    i_srst = 1'b0;
    repeat (4) @(negedge i_mclk);
    tbst_ctl_i.reset_tap();
    t_ident();
    t_bypass();
    t_boundary();
    t_instr();
    t_gpio();
    t_ident();
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge i_mclk);
    errors++;
    end_of_test();
  end
endmodule // boundary_scan_tap_tb

/* File: verif/tbst_ctl.sv */
`timescale 1ns/1ps
module tbst_ctl (
  input wire i_mclk, // Timing base
  input wire i_pin_tdo, // Port data out
  output logic o_tck, // Test clock, low between frames
  output logic o_tms, // Mode select
  output logic o_tdi // Data in, flipped once released
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One tck: change with the fall, read data out just before the rise
  task automatic step(input logic ms, di, output logic dout);
    @(negedge i_mclk);
    o_tck = 1'b0;
    o_tms = ms;
    o_tdi = di;
    repeat (4) @(negedge i_mclk);
    dout = i_pin_tdo;
    o_tck = 1'b1;
    repeat (3) @(negedge i_mclk);
  endtask
  // Park tck low; a stale data level would hide a missed shift
  task automatic park;
    @(negedge i_mclk);
    o_tck = 1'b0;
    o_tdi = ~o_tdi;
  endtask
  task automatic reset_tap;
    logic b;
    repeat (5) step(1'b1, o_tdi, b);
    step(1'b0, o_tdi, b);
    park();
  endtask
  // Idle to idle scan of n bits, IR or DR, lsb first
  task automatic scan(input logic [31:0] din, input int n, input logic ir,
                      output logic [31:0] dout);
    logic b;
    dout = 32'h0;
    step(1'b1, o_tdi, b);
    if (ir) step(1'b1, o_tdi, b);
    repeat (2) step(1'b0, o_tdi, b);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], b);
      dout[k] = b;
    end
    step(1'b1, o_tdi, b);
    step(1'b0, o_tdi, b);
    park();
  endtask
endmodule // tbst_ctl

/* File: verif/tbst_tap_checker.sv */
`timescale 1ns/1ps
module tbst_chk #(
  parameter NPIN = 8 // Digital pins
) (
  input wire i_mclk, // Clock
  input wire i_srst, // Reset
  input wire i_scan_port_select_pin, // Select
  input wire i_pin_tck, // Test clock
  input wire i_pin_tms, // Mode
  input wire i_pin_tdi, // Data in
  input wire o_pin_tdo, // Data out
  input wire o_pin_tdo_oe, // Data out enable
  input wire i_gpio_tdo_out, // GPIO drive
  input wire i_gpio_tdo_oe, // GPIO enable
  input wire [2:0] o_gpio_in, // Pin levels
  input wire [NPIN-1:0] i_core_out, // Core data
  input wire [NPIN-1:0] i_core_oe, // Core enable
  input wire [NPIN-1:0] i_pad_in, // Pad level
  input wire [NPIN-1:0] o_pad_out, // Pad data
  input wire [NPIN-1:0] o_pad_oe, // Pad enable
  input wire [NPIN-1:0] o_core_in // Core view
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Select windows of 4 and 8 cycles cover the two-stage synchroniser
  AST_GPIO_TDO: assert property (!i_scan_port_select_pin [*4] |->
    {o_pin_tdo, o_pin_tdo_oe} == {i_gpio_tdo_out, i_gpio_tdo_oe})
    else $error("data-out pin left its gpio drive");
  AST_GPIO_IN: assert property (!i_scan_port_select_pin [*4] |->
    o_gpio_in == {$past(i_pin_tck, 2), $past(i_pin_tms, 2),
    $past(i_pin_tdi, 2)}) else $error("gpio levels wrong");
  AST_GPIO_ZERO: assert property (i_scan_port_select_pin [*4] |->
    o_gpio_in == 3'h0) else $error("gpio levels leak in test");
  // Data out may only move a few cycles after a test clock fall
  AST_TDO_FALL: assert property (i_scan_port_select_pin [*8] ##0
    $changed(o_pin_tdo) |-> !$past(i_pin_tck, 2) && $past(i_pin_tck, 6))
    else $error("data out moved off a falling edge");
  AST_OE_FALL: assert property (i_scan_port_select_pin [*8] ##0
    $rose(o_pin_tdo_oe) |-> !$past(i_pin_tck, 2) && $past(i_pin_tck, 6))
    else $error("data out enable rose off a falling edge");
  AST_RST_OE: assert property (disable iff (1'b0)
    (i_srst && i_scan_port_select_pin) [*4] ##1 !i_srst |-> !o_pin_tdo_oe)
    else $error("data out driven after reset");
  AST_PAD_PASS: assert property (!i_scan_port_select_pin [*4] |->
    o_pad_out == i_core_out && o_pad_oe == i_core_oe)
    else $error("pads not on core drive");
  AST_CORE_IN: assert property (!i_scan_port_select_pin [*4] |->
    o_core_in == $past(i_pad_in, 2)) else $error("core input wrong");
endmodule // tbst_chk
bind tbst_tap tbst_chk #(.NPIN(NPIN)) tbst_chk_i (.i_mclk, .i_srst,
  .i_scan_port_select_pin, .i_pin_tck, .i_pin_tms, .i_pin_tdi, .o_pin_tdo,
  .o_pin_tdo_oe, .i_gpio_tdo_out, .i_gpio_tdo_oe, .o_gpio_in, .i_core_out,
  .i_core_oe, .i_pad_in, .o_pad_out, .o_pad_oe, .o_core_in);
